// File: include/sfs_pkg.sv
// Shared constants of the serial flash front end
package sfs_pkg;
    // ------------------------------------------------------------
    // Clock and array geometry
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 250_000_000;
    localparam int ADDR_W = 22;
    localparam int PAGE_OFS_W = 8;
    localparam int PAGE_IDX_W = 14;
    localparam int PAGE_BYTES = 256;
    localparam int SECTOR_OFS_W = 12;
    localparam int SECTOR_COUNT = 1024;
    localparam int BLOCK_OFS_W = 16;
    localparam int BLOCK_COUNT = 64;
    localparam int OTP_ADDR_W = 11;
    localparam int TIMER_W = 36;
    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRSR = 8'h01;
    localparam logic [7:0] CMD_PP = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RDSR = 8'h05;
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_SE = 8'h20;
    localparam logic [7:0] CMD_DREAD = 8'h3B;
    localparam logic [7:0] CMD_OTP_PP = 8'h42;
    localparam logic [7:0] CMD_OTP_READ = 8'h4B;
    localparam logic [7:0] CMD_CE = 8'hC7;
    localparam logic [7:0] CMD_BE = 8'hD8;
    // ------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int BP_W = 3;
    localparam int ST_OTP_LOCK = 6;
    localparam int ST_LOCK = 7;
    localparam logic [BP_W-1:0] BP_RST = 3'h0;
    localparam logic OTP_LOCK_RST = 1'b0;
    localparam logic LOCK_RST = 1'b0;
    localparam logic [1:0] SCOPE_SECTOR = 2'h0;
    localparam logic [1:0] SCOPE_BLOCK = 2'h1;
    localparam logic [1:0] SCOPE_CHIP = 2'h2;
    localparam logic [1:0] SCOPE_OTP = 2'h3;
    // ------------------------------------------------------------
    // Typical busy times
    // ------------------------------------------------------------
    localparam longint BYTE_PROG_NS = 7000;
    localparam longint PAGE_PROG_US = 1500;
    localparam longint SECTOR_ERASE_MS = 90;
    localparam longint BLOCK_ERASE_MS = 1000;
    localparam longint CHIP_ERASE_MS = 25000;
    localparam longint BYTE_PROG_CYC = (BYTE_PROG_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    localparam longint PAGE_PROG_CYC = PAGE_PROG_US * CLK_HZ / 64'd1_000_000;
    localparam longint SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLK_HZ / 64'd1000;
    localparam longint BLOCK_ERASE_CYC = BLOCK_ERASE_MS * CLK_HZ / 64'd1000;
    localparam longint CHIP_ERASE_CYC = CHIP_ERASE_MS * CLK_HZ / 64'd1000;
    // ------------------------------------------------------------
    // Transaction states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_CMD = 7'h02,
        S_ADDR = 7'h04,
        S_DUMMY = 7'h08,
        S_DATIN = 7'h10,
        S_DATOUT = 7'h20,
        S_SKIP = 7'h40
    } sfs_state_t;
endpackage

// File: include/sfs_busy_if.sv
// Handshake between the command logic and the busy timer
`timescale 1ns/100ps
interface sfs_busy_if;
    import sfs_pkg::*;
    logic start;
    logic [TIMER_W-1:0] cycles;
    logic busy;
    logic done;
    modport ctrl (output start, output cycles, input busy, input done);
    modport timer (input start, input cycles, output busy, output done);
endinterface

// File: logic/sfs_busy_timer.sv
// Busy timer for internal program and erase operations
`timescale 1ns/100ps
module sfs_busy_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control side
    sfs_busy_if.timer tm
);
    import sfs_pkg::*;

    logic [TIMER_W-1:0] remain;
    logic [TIMER_W-1:0] next_remain;
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;

    always_comb begin
        next_remain = remain;
        next_busy = busy;
        next_done = 1'b0;
        if (tm.start && !busy) begin
            next_remain = tm.cycles;
            next_busy = 1'b1;
        end else if (busy) begin
            if (remain <= TIMER_W'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_remain = '0;
            end else begin
                next_remain = remain - TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            remain <= next_remain;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign tm.busy = busy;
    assign tm.done = done;
endmodule

// File: logic/sfs_front_end.sv
// Serial flash front end: pin-level command engine and array requests
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module sfs_front_end #(
    parameter longint PAGE_PROG_CYCLES = sfs_pkg::PAGE_PROG_CYC,
    parameter longint SECTOR_ERASE_CYCLES = sfs_pkg::SECTOR_ERASE_CYC,
    parameter longint BLOCK_ERASE_CYCLES = sfs_pkg::BLOCK_ERASE_CYC,
    parameter longint CHIP_ERASE_CYCLES = sfs_pkg::CHIP_ERASE_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial pins
    input wire logic sck,
    input wire logic chipEnable_n,
    input wire logic hold_n,
    input wire logic writeProtect_n,
    input wire logic dual_io_lane_zero_in,
    output logic dual_io_lane_zero_out,
    output logic dual_io_lane_zero_oe,
    input wire logic dual_io_lane_one_in,
    output logic dual_io_lane_one_out,
    output logic dual_io_lane_one_oe,
    // Array requests
    output logic memWrite,
    output logic memRead,
    output logic memErase,
    output logic [1:0] memScope,
    output logic memOtp,
    output logic [sfs_pkg::ADDR_W-1:0] memAddr,
    output logic [7:0] memWrData,
    input wire logic [7:0] memRdData,
    // Status
    output logic opDone
);
    import sfs_pkg::*;

    if (PAGE_PROG_CYCLES < 1 || SECTOR_ERASE_CYCLES < 1 || BLOCK_ERASE_CYCLES < 1
        || CHIP_ERASE_CYCLES < 1 || CHIP_ERASE_CYCLES >= (64'd1 << TIMER_W)) begin
        $error("Busy cycle counts out of range");
    end

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    logic sckPrev;
    logic cePrev;
    logic active;
    logic sckRise;
    logic sckFall;
    logic ceFall;
    logic ceRise;

    assign active = !chipEnable_n && hold_n;
    assign sckRise = active && sck && !sckPrev;
    assign sckFall = active && !sck && sckPrev;
    assign ceFall = !chipEnable_n && cePrev;
    assign ceRise = chipEnable_n && !cePrev;

    sfs_busy_if tm ();

    sfs_busy_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tm(tm.timer)
    );

    // ------------------------------------------------------------
    // Transaction state
    // ------------------------------------------------------------
    sfs_state_t state, next_state;
    logic [4:0] bitCnt, next_bitCnt;
    logic [7:0] shiftIn, next_shiftIn;
    logic [7:0] cmd, next_cmd;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [7:0] outShift, next_outShift;
    logic [7:0] rdBuf, next_rdBuf;
    logic rdPend, next_rdPend;
    logic [8:0] byteCnt, next_byteCnt;
    logic armed, next_armed;
    logic driving, next_driving;
    logic wel, next_wel;
    logic [BP_W-1:0] bp, next_bp;
    logic lockBit, next_lockBit;
    logic otpLock, next_otpLock;
    logic next_memWrite, next_memRead, next_memErase, next_memOtp;
    logic [1:0] next_memScope;
    logic [ADDR_W-1:0] next_memAddr;
    logic [7:0] next_memWrData;
    logic next_io0Out, next_io0Oe, next_io1Out, next_io1Oe;
    logic [7:0] statusByte;
    logic [7:0] rxByte;
    logic [7:0] src;
    logic [TIMER_W-1:0] progCyc;
    logic isDual;
    logic isRead;

    // Top fraction of blocks protected, doubling per level
    function automatic logic inProtect(input logic [ADDR_W-1:0] a,
                                       input logic [BP_W-1:0] lvl);
        logic [6:0] cnt;
        cnt = 7'(7'h01 << (lvl - BP_W'(1)));
        if (lvl == '0) begin
            return 1'b0;
        end
        return ({1'b0, a[ADDR_W-1:BLOCK_OFS_W]} + cnt) >= 7'(BLOCK_COUNT);
    endfunction

    assign statusByte = {lockBit, otpLock, 1'b0, bp, wel, tm.busy};
    assign rxByte = {shiftIn[6:0], dual_io_lane_zero_in};
    assign isDual = (cmd == CMD_DREAD);
    assign isRead = (cmd == CMD_READ) || isDual || (cmd == CMD_OTP_READ);
    assign src = (cmd == CMD_RDSR) ? statusByte : rdBuf;
    // Programming costs bytes times the byte figure, capped at the page figure
    assign progCyc = (TIMER_W'(byteCnt) * TIMER_W'(BYTE_PROG_CYC) > TIMER_W'(PAGE_PROG_CYCLES))
        ? TIMER_W'(PAGE_PROG_CYCLES) : TIMER_W'(byteCnt) * TIMER_W'(BYTE_PROG_CYC);

    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shiftIn = shiftIn;
        next_cmd = cmd;
        next_addr = addr;
        next_outShift = outShift;
        next_rdBuf = rdPend ? memRdData : rdBuf;
        next_rdPend = 1'b0;
        next_byteCnt = byteCnt;
        next_armed = armed;
        next_driving = driving;
        next_wel = wel;
        next_bp = bp;
        next_lockBit = lockBit;
        next_otpLock = otpLock;
        next_memWrite = 1'b0;
        next_memRead = 1'b0;
        next_memErase = 1'b0;
        next_memOtp = memOtp;
        next_memScope = memScope;
        next_memAddr = memAddr;
        next_memWrData = memWrData;
        next_io0Out = dual_io_lane_zero_out;
        next_io1Out = dual_io_lane_one_out;
        tm.start = 1'b0;
        tm.cycles = '0;
        if (chipEnable_n) begin
            next_state = S_IDLE;
            next_driving = 1'b0;
        end
        if (ceFall) begin
            next_state = S_CMD;
            next_bitCnt = '0;
            next_byteCnt = '0;
            next_armed = 1'b0;
            next_driving = 1'b0;
        end else if (ceRise && armed) begin
            unique case (cmd)
                CMD_WREN: next_wel = 1'b1;
                CMD_WRDI: next_wel = 1'b0;
                CMD_WRSR: begin
                    next_wel = 1'b0;
                    // Lock bit only takes effect while the pin is low
                    if (!(lockBit && !writeProtect_n)) begin
                        next_bp = shiftIn[ST_BP_LO +: BP_W];
                        next_lockBit = shiftIn[ST_LOCK];
                        next_otpLock = otpLock || shiftIn[ST_OTP_LOCK];
                    end
                end
                CMD_PP, CMD_OTP_PP: begin
                    next_wel = 1'b0;
                    tm.start = 1'b1;
                    tm.cycles = progCyc;
                end
                CMD_SE: begin
                    next_wel = 1'b0;
                    next_memErase = 1'b1;
                    next_memScope = SCOPE_SECTOR;
                    next_memOtp = 1'b0;
                    next_memAddr = {addr[ADDR_W-1:SECTOR_OFS_W], SECTOR_OFS_W'(0)};
                    tm.start = 1'b1;
                    tm.cycles = TIMER_W'(SECTOR_ERASE_CYCLES);
                end
                CMD_BE: begin
                    next_wel = 1'b0;
                    next_memErase = 1'b1;
                    next_memScope = SCOPE_BLOCK;
                    next_memOtp = 1'b0;
                    next_memAddr = {addr[ADDR_W-1:BLOCK_OFS_W], BLOCK_OFS_W'(0)};
                    tm.start = 1'b1;
                    tm.cycles = TIMER_W'(BLOCK_ERASE_CYCLES);
                end
                CMD_CE: begin
                    next_wel = 1'b0;
                    next_memErase = 1'b1;
                    next_memScope = SCOPE_CHIP;
                    next_memOtp = 1'b0;
                    next_memAddr = '0;
                    tm.start = 1'b1;
                    tm.cycles = TIMER_W'(CHIP_ERASE_CYCLES);
                end
                default: next_wel = wel;
            endcase
            next_armed = 1'b0;
        end else if (sckRise) begin
            next_shiftIn = rxByte;
            next_bitCnt = bitCnt + 5'h01;
            unique case (state)
                S_CMD: if (bitCnt == 5'h07) begin
                    next_cmd = rxByte;
                    next_bitCnt = '0;
                    next_state = S_SKIP;
                    // While busy only the status poll is served
                    if (rxByte == CMD_RDSR) begin
                        next_state = S_DATOUT;
                    end else if (!tm.busy) begin
                        unique case (rxByte)
                            CMD_WREN, CMD_WRDI: next_armed = 1'b1;
                            CMD_WRSR: if (wel) next_state = S_DATIN;
                            CMD_READ, CMD_DREAD, CMD_OTP_READ: next_state = S_ADDR;
                            CMD_PP, CMD_OTP_PP, CMD_SE, CMD_BE: begin
                                if (wel) next_state = S_ADDR;
                            end
                            CMD_CE: next_armed = wel && (bp == '0);
                            default: next_state = S_SKIP;
                        endcase
                    end
                end
                S_ADDR: begin
                    next_addr = {addr[ADDR_W-2:0], dual_io_lane_zero_in};
                    if (bitCnt == 5'h17) begin
                        next_bitCnt = '0;
                        next_state = S_SKIP;
                        if (isRead) begin
                            next_memRead = 1'b1;
                            next_rdPend = 1'b1;
                            next_memOtp = (cmd == CMD_OTP_READ);
                            next_memAddr = {addr[ADDR_W-2:0], dual_io_lane_zero_in};
                            next_state = isDual ? S_DUMMY : S_DATOUT;
                        end else if (cmd == CMD_OTP_PP) begin
                            if (!otpLock) next_state = S_DATIN;
                        end else if (!inProtect(next_addr, bp)) begin
                            next_state = (cmd == CMD_PP) ? S_DATIN : S_SKIP;
                            next_armed = (cmd != CMD_PP);
                        end
                    end
                end
                S_DUMMY: if (bitCnt == 5'h07) begin
                    next_bitCnt = '0;
                    next_state = S_DATOUT;
                end
                S_DATIN: if (bitCnt == 5'h07) begin
                    next_bitCnt = '0;
                    next_armed = 1'b1;
                    if (cmd == CMD_WRSR) begin
                        next_state = S_SKIP;
                    end else if (byteCnt != 9'(PAGE_BYTES)) begin
                        next_byteCnt = byteCnt + 9'h001;
                        next_memWrite = 1'b1;
                        next_memWrData = rxByte;
                        next_memOtp = (cmd == CMD_OTP_PP);
                        next_memScope = (cmd == CMD_OTP_PP) ? SCOPE_OTP : SCOPE_SECTOR;
                        next_memAddr = addr;
                        // Offset wraps inside the page, page index held
                        next_addr = {addr[ADDR_W-1:PAGE_OFS_W],
                                     addr[PAGE_OFS_W-1:0] + PAGE_OFS_W'(1)};
                    end
                end
                default: next_bitCnt = bitCnt;
            endcase
        end else if (sckFall && state == S_DATOUT) begin
            next_driving = 1'b1;
            if (bitCnt == '0) begin
                next_io1Out = src[7];
                next_io0Out = src[6];
                next_outShift = isDual ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
                if (isRead) begin
                    next_addr = (cmd == CMD_OTP_READ)
                        ? {addr[ADDR_W-1:OTP_ADDR_W], addr[OTP_ADDR_W-1:0] + OTP_ADDR_W'(1)}
                        : addr + ADDR_W'(1);
                    next_memAddr = next_addr;
                    next_memRead = 1'b1;
                    next_rdPend = 1'b1;
                end
            end else begin
                next_io1Out = outShift[7];
                next_io0Out = outShift[6];
                next_outShift = isDual ? {outShift[5:0], 2'b00} : {outShift[6:0], 1'b0};
            end
            next_bitCnt = isDual ? ((bitCnt == 5'h06) ? '0 : bitCnt + 5'h02)
                                 : ((bitCnt == 5'h07) ? '0 : bitCnt + 5'h01);
        end
        // Hold floats the lanes but keeps every counter
        next_io1Oe = next_driving && !chipEnable_n && hold_n;
        next_io0Oe = next_io1Oe && isDual;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sckPrev <= 1'b0;
            cePrev <= 1'b1;
            state <= S_IDLE;
            bitCnt <= '0;
            shiftIn <= '0;
            cmd <= '0;
            addr <= '0;
            outShift <= '0;
            rdBuf <= '0;
            rdPend <= 1'b0;
            byteCnt <= '0;
            armed <= 1'b0;
            driving <= 1'b0;
            wel <= 1'b0;
            bp <= BP_RST;
            lockBit <= LOCK_RST;
            otpLock <= OTP_LOCK_RST;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            memErase <= 1'b0;
            memScope <= SCOPE_SECTOR;
            memOtp <= 1'b0;
            memAddr <= '0;
            memWrData <= '0;
            dual_io_lane_zero_out <= 1'b0;
            dual_io_lane_zero_oe <= 1'b0;
            dual_io_lane_one_out <= 1'b0;
            dual_io_lane_one_oe <= 1'b0;
            opDone <= 1'b0;
        end else begin
            sckPrev <= hold_n ? sck : sckPrev;
            cePrev <= chipEnable_n;
            state <= next_state;
            bitCnt <= next_bitCnt;
            shiftIn <= next_shiftIn;
            cmd <= next_cmd;
            addr <= next_addr;
            outShift <= next_outShift;
            rdBuf <= next_rdBuf;
            rdPend <= next_rdPend;
            byteCnt <= next_byteCnt;
            armed <= next_armed;
            driving <= next_driving;
            wel <= next_wel;
            bp <= next_bp;
            lockBit <= next_lockBit;
            otpLock <= next_otpLock;
            memWrite <= next_memWrite;
            memRead <= next_memRead;
            memErase <= next_memErase;
            memScope <= next_memScope;
            memOtp <= next_memOtp;
            memAddr <= next_memAddr;
            memWrData <= next_memWrData;
            dual_io_lane_zero_out <= next_io0Out;
            dual_io_lane_zero_oe <= next_io0Oe;
            dual_io_lane_one_out <= next_io1Out;
            dual_io_lane_one_oe <= next_io1Oe;
            opDone <= tm.done;
        end
    end
endmodule

// File: tb/sfs_front_end_properties.sv
// Concurrent checks on the serial flash front end ports
`timescale 1ns/100ps
module sfs_front_end_properties
    import sfs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial pins
    input wire logic sck,
    input wire logic chipEnable_n,
    input wire logic hold_n,
    input wire logic dual_io_lane_zero_oe,
    input wire logic dual_io_lane_one_out,
    input wire logic dual_io_lane_one_oe,
    // Array requests and status
    input wire logic memWrite,
    input wire logic memErase,
    input wire logic [1:0] memScope,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic opDone
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic pageSeen;
    logic next_pageSeen;
    logic [PAGE_IDX_W-1:0] pageLast;
    logic [PAGE_IDX_W-1:0] next_pageLast;
    always_comb begin
        next_pageSeen = chipEnable_n ? 1'b0 : (pageSeen | memWrite);
        next_pageLast = memWrite ? memAddr[ADDR_W-1:PAGE_OFS_W] : pageLast;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pageSeen <= 1'b0;
            pageLast <= '0;
        end else begin
            pageSeen <= next_pageSeen;
            pageLast <= next_pageLast;
        end
    end
    write_pulse_a: assert property (memWrite |=> !memWrite)
        else $error("write request longer than one cycle");
    frame_write_a: assert property (chipEnable_n && $past(chipEnable_n, 3) |-> !memWrite)
        else $error("write outside a frame");
    hold_release_a: assert property (!hold_n ##1 !hold_n |-> !dual_io_lane_one_oe)
        else $error("lane driven during hold");
    ce_release_a: assert property (chipEnable_n ##1 chipEnable_n |-> !dual_io_lane_one_oe)
        else $error("lane driven while deselected");
    erase_scope_a: assert property (memErase |-> memScope != SCOPE_OTP)
        else $error("erase of unsupported size");
    out_on_fall_a: assert property (dual_io_lane_one_oe && $past(dual_io_lane_one_oe)
        && $changed(dual_io_lane_one_out) |-> !sck) else $error("output moved with clock high");
    done_pulse_a: assert property (opDone |=> !opDone)
        else $error("completion longer than one cycle");
    one_page_a: assert property (memWrite && pageSeen |->
        memAddr[ADDR_W-1:PAGE_OFS_W] == pageLast) else $error("program crossed a page");
    dual_pair_a: assert property (dual_io_lane_zero_oe |-> dual_io_lane_one_oe)
        else $error("lane zero driven alone");
    cover property (memWrite && pageSeen);
    cover property (memErase);
    cover property (opDone);
endmodule
bind sfs_front_end sfs_front_end_properties u_sfs_front_end_properties (.*);

// File: tb/sfs_host_model.sv
// Host controller model driving the serial link in clock mode 0
`timescale 1ns/100ps
module sfs_host_model (
    // Clock
    input wire logic clk_sys,
    // Serial link
    output logic sck,
    output logic chipEnable_n,
    output logic hold_n,
    output logic laneOut,
    input wire logic laneIn
);
    initial begin
        sck = 1'b0;
        chipEnable_n = 1'b1;
        hold_n = 1'b1;
        laneOut = 1'b0;
    end
    // Six system cycles per half keeps the front end's edge detect safe
    task automatic half();
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic frameStart();
        chipEnable_n = 1'b0;
        half();
    endtask
    task automatic frameEnd();
        half();
        chipEnable_n = 1'b1;
        laneOut = ~laneOut;
        half();
    endtask
    task automatic xbyte(input logic [7:0] tx, input int holdAt, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            laneOut = tx[i];
            if (i == holdAt) begin
                hold_n = 1'b0;
                repeat (3) half();
                hold_n = 1'b1;
            end
            half();
            rx[i] = laneIn;
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask
endmodule

// File: tb/sfs_front_end_test.sv
// Self-checking bench of the serial flash front end
`timescale 1ns/100ps
module sfs_front_end_test;
    import sfs_pkg::*;
    typedef struct {logic [7:0] cmd; logic [7:0] status;} sfs_row_t;
    sfs_row_t rows [3] = '{'{CMD_WREN, 8'h02}, '{CMD_WRDI, 8'h00}, '{CMD_WREN, 8'h02}};
    logic [7:0] eraseCmd [3] = '{CMD_SE, CMD_BE, CMD_CE};
    logic [1:0] eraseScope [3] = '{SCOPE_SECTOR, SCOPE_BLOCK, SCOPE_CHIP};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] memRdData = 8'hA5;
    logic [7:0] rx;
    logic writeProtect_n = 1'b1;
    logic [7:0] lastData = 8'h00;
    logic [ADDR_W-1:0] lastAddr = '0;
    int err_count = 0;
    int samples_checked = 0;
    int writes = 0;
    int erases = 0;
    int dones = 0;
    wire sck, chipEnable_n, hold_n, hostLane, l0Out, l0Oe, l1Out, l1Oe, memWrite, memErase, opDone;
    wire [1:0] memScope;
    wire [ADDR_W-1:0] memAddr;
    wire [7:0] memWrData;
    wire l0In = l0Oe ? l0Out : hostLane;
    wire l1In = l1Oe ? l1Out : 1'b0;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (memWrite) begin
            writes++;
            lastAddr = memAddr;
            lastData = memWrData;
        end
        if (memErase) erases++;
        if (opDone) dones++;
    end
    sfs_host_model u_sfs_host_model (.clk_sys(clk_sys), .sck(sck), .chipEnable_n(chipEnable_n),
        .hold_n(hold_n), .laneOut(hostLane), .laneIn(l1In));
    sfs_front_end #(.PAGE_PROG_CYCLES(20), .SECTOR_ERASE_CYCLES(20), .BLOCK_ERASE_CYCLES(20),
        .CHIP_ERASE_CYCLES(20)) u_sfs_front_end (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck),
        .chipEnable_n(chipEnable_n), .hold_n(hold_n), .writeProtect_n(writeProtect_n),
        .dual_io_lane_zero_in(l0In), .dual_io_lane_zero_out(l0Out), .dual_io_lane_zero_oe(l0Oe),
        .dual_io_lane_one_in(l1In), .dual_io_lane_one_out(l1Out), .dual_io_lane_one_oe(l1Oe),
        .memWrite(memWrite), .memRead(), .memErase(memErase), .memScope(memScope), .memOtp(),
        .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData), .opDone(opDone));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmd1(input logic [7:0] c);
        u_sfs_host_model.frameStart();
        u_sfs_host_model.xbyte(c, -1, rx);
        u_sfs_host_model.frameEnd();
    endtask
    // Leaves the frame open for data bytes
    task automatic addrOp(input logic [7:0] c, input logic [23:0] a);
        u_sfs_host_model.frameStart();
        u_sfs_host_model.xbyte(c, -1, rx);
        for (int k = 2; k >= 0; k--) u_sfs_host_model.xbyte(a[8*k +: 8], -1, rx);
    endtask
    task automatic readStatus(input int holdAt, output logic [7:0] st);
        u_sfs_host_model.frameStart();
        u_sfs_host_model.xbyte(CMD_RDSR, holdAt, st);
        u_sfs_host_model.xbyte(8'h00, -1, st);
        u_sfs_host_model.frameEnd();
    endtask
    task automatic waitDone(input int target);
        for (int i = 0; i < 500 && dones < target; i++) @(negedge clk_sys);
    endtask
    initial begin
        #100_000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({memWrite, memErase, opDone, l0Oe, l1Oe}, 5'h00);
        foreach (rows[i]) begin
            cmd1(rows[i].cmd);
            readStatus(-1, rx);
            check(rx, rows[i].status);
        end
        cmd1(CMD_WRDI);
        addrOp(CMD_PP, 24'h000150);
        u_sfs_host_model.xbyte(8'h3C, -1, rx);
        u_sfs_host_model.frameEnd();
        check(writes, 0);
        cmd1(CMD_WREN);
        addrOp(CMD_PP, 24'h000150);
        u_sfs_host_model.xbyte(8'h3C, -1, rx);
        u_sfs_host_model.xbyte(8'hC3, -1, rx);
        u_sfs_host_model.frameEnd();
        check(writes, 2);
        check(lastAddr, 22'h000151);
        check(lastData, 8'hC3);
        waitDone(1);
        check(dones, 1);
        cmd1(CMD_WREN);
        readStatus(3, rx);
        check(rx, 8'h02);
        foreach (eraseCmd[k]) begin
            cmd1(CMD_WREN);
            if (eraseScope[k] == SCOPE_CHIP) u_sfs_host_model.frameStart();
            if (eraseScope[k] == SCOPE_CHIP) u_sfs_host_model.xbyte(eraseCmd[k], -1, rx);
            else addrOp(eraseCmd[k], 24'h001234);
            u_sfs_host_model.frameEnd();
            waitDone(k + 2);
            check(erases, k + 1);
            check(memScope, eraseScope[k]);
            check(dones, k + 2);
        end
        for (int d = 0; d < 2; d++) begin
            addrOp(d ? CMD_DREAD : CMD_READ, 24'h000010);
            repeat (d + 1) u_sfs_host_model.xbyte(8'h00, -1, rx);
            u_sfs_host_model.frameEnd();
            check(rx, d ? 8'hCC : 8'hA5);
        end
        for (int k = 0; k < 3; k++) begin
            cmd1(CMD_WREN);
            addrOp(k[1] ? CMD_SE : CMD_WRSR, k[0] ? 24'h0 : 24'h9C9C9C);
            u_sfs_host_model.frameEnd();
            writeProtect_n = 1'b0;
        end
        check(erases, 3);
        stop_test();
    end
endmodule
